// ===== sim/spa_arbiter_tb.sv
module spa_arbiter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spa_pkg::*;

    logic        mclk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [1:0]  go = '0;
    logic [15:0] len = '0;
    logic [1:0]  req;
    logic [1:0]  grant;
    logic [31:0] val_in_out;
    logic [15:0] br_val;
    logic [31:0] cv = 32'hFF052211;
    logic [15:0] br_in = 16'hA55A;
    logic [1:0]  br_oe;
    logic        busy;
    logic [1:0]  sel_in = 2'h0;
    logic [1:0]  sel_out;
    logic [1:0]  irq_in = 2'h0;
    logic [1:0]  irq_out;
    int          error_cnt = 0;
    int          compares = 0;

    initial forever #10 mclk_in = ~mclk_in;

    spa_arbiter #(.ROLE_W(8)) i_spa_arbiter (
        .mclk_in(mclk_in), .nrst_in(nrst_in),
        .client_request_in(req), .client_grant_out(grant),
        .client_value_out_in(cv),
        .client_value_outen_in(4'h3), .client_role_used_in(4'h7),
        .client_value_in_out(val_in_out),
        .device_select_in(sel_in),
        .bridge_value_out(br_val), .bridge_outen_out(br_oe),
        .bridge_value_in(br_in), .bridge_busy_out(busy),
        .device_select_out(sel_out), .bridge_interrupt_in(irq_in),
        .device_interrupt_out(irq_out));

    spa_client_model i_spa_client_model (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .go_in(go), .len_in(len),
        .request_out(req), .grant_in(grant));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // -------------------------------------------------------------
    // Bridge side follows the owner every cycle
    // -------------------------------------------------------------
    always @(negedge mclk_in) begin
        if (nrst_in) begin
            check(busy, |grant);
            case (grant)
                2'b01: check({br_oe, br_val}, 18'h32211);
                2'b10: check({br_oe, br_val}, 18'h00005);
                2'b00: check({br_oe, br_val}, 18'h0);
                default: check(grant, 2'b00);
            endcase
        end
    end

    task automatic run(input logic [1:0] g, input logic [15:0] l);
        int n;
        len <= l;
        go <= g;
        @(negedge mclk_in);
        go <= '0;
        repeat (3) @(negedge mclk_in);
        for (n = 0; n < 60 && (req !== 2'b00 || grant !== 2'b00); n++)
            @(negedge mclk_in);
        if (n == 60) begin
            check(req | grant, 2'b00);
            final_report();
        end
    endtask : run

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_idle;
        check({grant, busy, br_val}, 19'h0);
        nrst_in <= 1'b1;
        repeat (5) @(negedge mclk_in);
        check(grant, 2'b00);
        check(val_in_out, 32'h005AA55A);
        sel_in <= 2'h2;
        irq_in <= 2'h1;
        br_in  <= 16'h0FF0;
        @(negedge mclk_in);
        check({sel_out, irq_out}, 4'h9);
        check(val_in_out, 32'h00F00FF0);
        $display("Test idle done");
    endtask : t_idle

    task automatic t_single;
        run(2'b01, 16'h0003);
        check(i_spa_client_model.start_cyc[0] -
              i_spa_client_model.req_cyc[0], 1);
        check(i_spa_client_model.grant_cnt[0], 3);
        $display("Test single done");
    endtask : t_single

    task automatic t_short;
        run(2'b10, 16'h0200);
        check(i_spa_client_model.grant_cnt[1], 2);
        $display("Test short done");
    endtask : t_short

    task automatic t_contend;
        run(2'b11, 16'h0303);
        check(i_spa_client_model.start_cyc[1] -
              i_spa_client_model.start_cyc[0], 3);
        check(i_spa_client_model.grant_cnt[1], 3);
        $display("Test contend done");
    endtask : t_contend

    initial begin
        repeat (2) @(negedge mclk_in);
        t_idle();
        t_single();
        t_short();
        t_contend();
        final_report();
    end

endmodule : spa_arbiter_tb

// ===== sim/spa_client_model.sv
module spa_client_model #(
    parameter int N = 2
) (
    // Clock and reset
    input  wire logic           mclk_in,
    input  wire logic           nrst_in,
    // Start pulse and access length, eight bits per client
    input  wire logic [N-1:0]   go_in,
    input  wire logic [N*8-1:0] len_in,
    // Handshake toward the arbiter
    output logic      [N-1:0]   request_out,
    input  wire logic [N-1:0]   grant_in
);
    timeunit 1ns;
    timeprecision 1ps;

    int cyc;
    int cnt       [N];
    int req_cyc   [N];
    int start_cyc [N];
    int grant_cnt [N];

    initial begin
        cyc = 0;
        foreach (cnt[c]) cnt[c] = 0;
    end

    // -------------------------------------------------------------
    // Controllers, each with its own request and grant pair
    // -------------------------------------------------------------
    // Acts on the falling edge so the arbiter samples settled levels
    always @(negedge mclk_in) begin
        cyc = cyc + 1;
        for (int c = 0; c < N; c++) begin
            if (!nrst_in) begin
                request_out[c] = 1'b0;
                cnt[c] = 0;
            end else if (!request_out[c] && go_in[c] && cnt[c] == 0 &&
                         !grant_in[c]) begin
                request_out[c] = 1'b1;
                req_cyc[c] = cyc;
            end else if (grant_in[c]) begin
                if (cnt[c] == 0) start_cyc[c] = cyc;
                cnt[c] = cnt[c] + 1;
                grant_cnt[c] = cnt[c];
                // Held until granted, dropped in the next-to-last owned cycle
                if (cnt[c] == int'(len_in[c*8 +: 8]) - 1)
                    request_out[c] = 1'b0;
            end else begin
                cnt[c] = 0;
            end
        end
    end

endmodule : spa_client_model

// ===== src/spa_arbiter.sv
// Contract
// [RULE1] Each client carries a one-bit request and a one-bit grant.
// [RULE2] One client port per controller, each with its own request and grant.
// [RULE3] Request while grant is low asks for the bus this cycle.
// [RULE4] Request while granted asks for next cycle; drop it in last cycle.
// [RULE5] Request may rise right after the last cycle for back-to-back use.
// [RULE6] Request is held until granted; shortest access is two cycles.
// [RULE7] Grant rises on request and falls one cycle after request drops.
// [RULE8] No grant is given while nobody requests.
// [RULE9] Same-role client signals are merged onto one shared pin group.
// [RULE10] Each shared role has out, in and output enable parts.
// [RULE11] One combined bus carries the granted client's shared signals.
// [RULE12] Narrower signals align at bit zero; upper pins drive zero.
// [RULE13] Unshared selects and interrupts pass through unchanged.
// [RULE14] All clients and the bridge side share one clock.
// [RULE15] Value signals are 1 to 1024 bits wide, in toward the client.
// [RULE16] Each shared signal has an optional one-bit output enable.
// [RULE17] The granted client owns the pins from its first grant cycle.
// [RULE18] Round-robin among requesters; owner keeps bus until done.
`include "spa_consts.svh"

module spa_arbiter #(
    parameter int N_CLIENTS = 2,
    parameter int N_ROLES   = 2,
    parameter int ROLE_W    = 16,
    parameter int SEL_W     = 1,
    parameter int IRQ_W     = 1
) (
    // Clock and reset
    input  wire logic                            mclk_in,
    input  wire logic                            nrst_in,
    // Client handshake, one pair per controller
    input  wire logic [N_CLIENTS-1:0]            client_request_in,
    output logic      [N_CLIENTS-1:0]            client_grant_out,
    // Client shared signals, per client and role
    input  wire logic [N_CLIENTS*N_ROLES*ROLE_W-1:0] client_value_out_in,
    input  wire logic [N_CLIENTS*N_ROLES-1:0]    client_value_outen_in,
    input  wire logic [N_CLIENTS*N_ROLES-1:0]    client_role_used_in,
    output logic      [N_CLIENTS*N_ROLES*ROLE_W-1:0] client_value_in_out,
    // Unshared client signals
    input  wire logic [N_CLIENTS*SEL_W-1:0]      device_select_in,
    // Bridge side
    output logic      [N_ROLES*ROLE_W-1:0]       bridge_value_out,
    output logic      [N_ROLES-1:0]              bridge_outen_out,
    input  wire logic [N_ROLES*ROLE_W-1:0]       bridge_value_in,
    output logic                                 bridge_busy_out,
    output logic      [N_CLIENTS*SEL_W-1:0]      device_select_out,
    input  wire logic [N_CLIENTS*IRQ_W-1:0]      bridge_interrupt_in,
    output logic      [N_CLIENTS*IRQ_W-1:0]      device_interrupt_out
);
    import spa_pkg::*;

    localparam int IDX_W = (N_CLIENTS > 1) ? $clog2(N_CLIENTS) : 1;

    typedef struct packed {
        spa_phase_t            phase;
        logic [IDX_W-1:0]      owner;
        logic [IDX_W-1:0]      last;
        logic                  tail;
    } spa_state_t;

    spa_state_t       st_q;
    spa_state_t       st_d;
    logic             pick_hit;
    logic [IDX_W-1:0] pick_win;

    // Width mask: a role a client does not use reads as all zero
    function automatic logic [ROLE_W-1:0] spa_mask(
        input logic [ROLE_W-1:0] v,
        input logic              used
    );
        spa_mask = used ? v : '0; // see [RULE12]
    endfunction : spa_mask

    // ------------------------------------------------------------
    // Round-robin choice
    // ------------------------------------------------------------
    spa_rr_pick #(
        .N_CLIENTS (N_CLIENTS),
        .IDX_W     (IDX_W)
    ) u_pick (
        .req_in  (client_request_in),
        .last_in (st_q.last),
        .hit_out (pick_hit),
        .win_out (pick_win)
    ); // see [RULE18]

    // ------------------------------------------------------------
    // Arbitration state
    // ------------------------------------------------------------
    // tail marks the extra grant cycle after the owner drops request
    always_comb begin
        st_d = st_q;
        case (st_q.phase)
            SPA_IDLE: begin
                st_d.tail = 1'b0;
                if (pick_hit) begin // see [RULE3] see [RULE8]
                    st_d.phase = SPA_BUSY;
                    st_d.owner = pick_win;
                    st_d.last  = pick_win;
                end
            end
            SPA_BUSY: begin
                if (st_q.tail) begin
                    // Access over; back-to-back request rearbitrates
                    if (pick_hit) begin
                        st_d.tail  = 1'b0;
                        st_d.owner = pick_win;
                        st_d.last  = pick_win; // see [RULE5]
                    end else begin
                        st_d.phase = SPA_IDLE;
                        st_d.tail  = 1'b0;
                    end
                end else if (!client_request_in[st_q.owner]) begin
                    st_d.tail = 1'b1; // see [RULE4] see [RULE7]
                end
            end
            default: begin
                st_d.phase = SPA_IDLE;
                st_d.tail  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin // see [RULE14]
        if (!nrst_in) begin
            st_q.phase <= SPA_IDLE;
            st_q.owner <= '0;
            st_q.last  <= IDX_W'(N_CLIENTS - 1);
            st_q.tail  <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Grants and shared pin routing
    // ------------------------------------------------------------
    // Grants come straight from the state so data may flow in the
    // first grant cycle without a further register stage.
    always_comb begin
        client_grant_out = '0;
        if (st_q.phase == SPA_BUSY) begin
            client_grant_out[st_q.owner] = 1'b1; // see [RULE1] see [RULE2]
        end
    end

    assign bridge_busy_out = (st_q.phase == SPA_BUSY);

    always_comb begin
        int r;
        int b;
        r = 0;
        b = 0;
        bridge_value_out = '0;
        bridge_outen_out = '0;
        if (st_q.phase == SPA_BUSY) begin // see [RULE17]
            for (r = 0; r < N_ROLES; r++) begin
                b = int'(st_q.owner) * N_ROLES + r;
                bridge_value_out[r*ROLE_W +: ROLE_W] = spa_mask(
                    client_value_out_in[b*ROLE_W +: ROLE_W],
                    client_role_used_in[b]); // see [RULE9] see [RULE11]
                bridge_outen_out[r] = client_value_outen_in[b] &
                    client_role_used_in[b]; // see [RULE10] see [RULE16]
            end
        end
    end

    // Inputs fan out to every client; only the granted one may use them
    always_comb begin
        int c;
        int r;
        int b;
        c = 0;
        r = 0;
        b = 0;
        client_value_in_out = '0;
        for (c = 0; c < N_CLIENTS; c++) begin
            for (r = 0; r < N_ROLES; r++) begin
                b = c * N_ROLES + r;
                client_value_in_out[b*ROLE_W +: ROLE_W] = spa_mask(
                    bridge_value_in[r*ROLE_W +: ROLE_W],
                    client_role_used_in[b]); // see [RULE15]
            end
        end
    end

    // Unshared signals pass straight through
    assign device_select_out    = device_select_in; // see [RULE13]
    assign device_interrupt_out = bridge_interrupt_in; // see [RULE13]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // First cycle in which the granted client 0 has let request go
    sequence s_drop_c0;
        client_grant_out[0] && $fell(client_request_in[0]);
    endsequence

    property p_no_idle_grant;
        @(posedge mclk_in) disable iff (!nrst_in)
        (client_request_in == '0 && st_q.phase == SPA_IDLE)
            |=> (client_grant_out == '0);
    endproperty
    a_no_idle_grant: assert property (p_no_idle_grant) // see [RULE8]
        else $error("grant given with no request");

    property p_onehot;
        @(posedge mclk_in) disable iff (!nrst_in)
        $onehot0(client_grant_out);
    endproperty
    a_onehot: assert property (p_onehot) // see [RULE2]
        else $error("more than one grant");

    property p_grant_soon;
        @(posedge mclk_in) disable iff (!nrst_in)
        (st_q.phase == SPA_IDLE && client_request_in != '0)
            |=> (client_grant_out != '0);
    endproperty
    a_grant_soon: assert property (p_grant_soon) // see [RULE3]
        else $error("request not granted next cycle");

    property p_tail;
        @(posedge mclk_in) disable iff (!nrst_in)
        s_drop_c0 |=> client_grant_out[0];
    endproperty
    a_tail: assert property (p_tail) // see [RULE7]
        else $error("grant fell too early");

    property p_tail_end;
        @(posedge mclk_in) disable iff (!nrst_in)
        s_drop_c0 ##1 (client_grant_out[0] && !client_request_in[0])
            |=> !client_grant_out[0];
    endproperty
    a_tail_end: assert property (p_tail_end) // see [RULE7]
        else $error("grant held after tail");

    property p_hold_owner;
        @(posedge mclk_in) disable iff (!nrst_in)
        (client_grant_out[0] && client_request_in[0] && !st_q.tail)
            |=> client_grant_out[0];
    endproperty
    a_hold_owner: assert property (p_hold_owner) // see [RULE18]
        else $error("owner lost bus mid access");

    property p_zero_idle;
        @(posedge mclk_in) disable iff (!nrst_in)
        (client_grant_out == '0) |-> (bridge_outen_out == '0 &&
            bridge_value_out == '0);
    endproperty
    a_zero_idle: assert property (p_zero_idle) // see [RULE12]
        else $error("bridge driven with no owner");

    property p_route0;
        @(posedge mclk_in) disable iff (!nrst_in)
        (client_grant_out[0] && client_role_used_in[0]) |->
            (bridge_value_out[ROLE_W-1:0] ==
             client_value_out_in[ROLE_W-1:0]);
    endproperty
    a_route0: assert property (p_route0) // see [RULE11] see [RULE17]
        else $error("granted value not on bridge");

    property p_pass;
        @(posedge mclk_in) disable iff (!nrst_in)
        device_select_out == device_select_in;
    endproperty
    a_pass: assert property (p_pass) // see [RULE13]
        else $error("select not passed through");

    property p_min_access;
        @(posedge mclk_in) disable iff (!nrst_in)
        $rose(client_grant_out[0]) |=> client_grant_out[0];
    endproperty
    a_min_access: assert property (p_min_access) // see [RULE6]
        else $error("access shorter than two cycles");

    property p_rearb;
        @(posedge mclk_in) disable iff (!nrst_in)
        (st_q.phase == SPA_BUSY && st_q.tail && client_request_in != '0)
            |=> (client_grant_out != '0);
    endproperty
    a_rearb: assert property (p_rearb) // see [RULE5]
        else $error("no back-to-back grant after tail");

    property p_upper_zero;
        @(posedge mclk_in) disable iff (!nrst_in)
        (client_grant_out[N_CLIENTS-1] &&
         !client_role_used_in[N_CLIENTS*N_ROLES-1]) |->
            (bridge_value_out[N_ROLES*ROLE_W-1 -: ROLE_W] == '0 &&
             !bridge_outen_out[N_ROLES-1]);
    endproperty
    a_upper_zero: assert property (p_upper_zero) // see [RULE12]
        else $error("unused role of owner not zero");

    property p_outen0;
        @(posedge mclk_in) disable iff (!nrst_in)
        (client_grant_out[0] && client_role_used_in[0]) |->
            (bridge_outen_out[0] == client_value_outen_in[0]);
    endproperty
    a_outen0: assert property (p_outen0) // see [RULE16]
        else $error("output enable not routed");

    property p_in_unused;
        @(posedge mclk_in) disable iff (!nrst_in)
        !client_role_used_in[N_CLIENTS*N_ROLES-1] |->
            (client_value_in_out[N_CLIENTS*N_ROLES*ROLE_W-1 -: ROLE_W] == '0);
    endproperty
    a_in_unused: assert property (p_in_unused) // see [RULE15]
        else $error("unused input role not zero");

    property p_irq_pass;
        @(posedge mclk_in) disable iff (!nrst_in)
        device_interrupt_out == bridge_interrupt_in;
    endproperty
    a_irq_pass: assert property (p_irq_pass) // see [RULE13]
        else $error("interrupt not passed through");

endmodule : spa_arbiter

// ===== src/spa_consts.svh
`ifndef SPA_CONSTS_SVH
`define SPA_CONSTS_SVH

// Bit zero, where every narrower shared signal is aligned
`define SPA_ALIGN_BIT    0
// Grant stays up this many cycles after the owner drops request
`define SPA_GRANT_TAIL   1
// Shortest access that the handshake allows, in cycles
`define SPA_MIN_ACCESS   2
// Widest value signal of one logical tristate signal
`define SPA_MAX_WIDTH    1024

`endif

// ===== src/spa_pkg.sv
`include "spa_consts.svh"

package spa_pkg;

    // Arbiter phase, one-hot
    typedef enum logic [1:0] {
        SPA_IDLE = 2'h1,
        SPA_BUSY = 2'h2
    } spa_phase_t;

endpackage : spa_pkg

// ===== src/spa_rr_pick.sv
`include "spa_consts.svh"

module spa_rr_pick #(
    parameter int N_CLIENTS = 2,
    parameter int IDX_W     = 1
) (
    // Candidates and priority pointer
    input  wire logic [N_CLIENTS-1:0] req_in,
    input  wire logic [IDX_W-1:0]     last_in,
    // Winner
    output logic                      hit_out,
    output logic [IDX_W-1:0]          win_out
);
    import spa_pkg::*;

    // Start just past the last owner so every client gets its turn
    always_comb begin
        int k;
        int c;
        k = 0;
        c = 0;
        hit_out = 1'b0;
        win_out = '0;
        for (k = N_CLIENTS; k >= 1; k--) begin
            c = (int'(last_in) + k) % N_CLIENTS;
            if (req_in[c]) begin
                hit_out = 1'b1;
                win_out = IDX_W'(c);
            end
        end
    end

endmodule : spa_rr_pick
